//--- src/c2h_byp_consts.vh
`ifndef C2H_BYP_CONSTS_VH
`define C2H_BYP_CONSTS_VH

// ------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_ARM 8'h04
`define REG_INT_STATUS 8'h08
`define REG_INT_CLEAR 8'h0c
`define REG_INT_ENABLE 8'h10
`define REG_ERR_QUEUE 8'h14
`define REG_DESC_COUNT 8'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_RING_IRQ_EN_BIT 1
`define ARM_BIT 0

// Event bits of the status, clear and enable registers
`define EV_DESC_DONE 0
`define EV_NOP 1
`define EV_QUEUE_ERR 2
`define EV_MARKER 3
`define EV_HOST_IRQ 4
`define EV_IRQ_SUPPRESSED 5
`define EV_COUNT 6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CTRL_RESET 2'h0
`define INT_ENABLE_RESET 6'h00

// ------------------------------------------------------------
// Descriptor field widths
// ------------------------------------------------------------
`define LEN_W 28
`define QID_W 11
`define FUNC_W 8
`define CIDX_W 16
`define PORT_W 3
`define ADDR_W 64

`endif

//--- src/c2h_mm_byp_in.v
// Operation
// RULE1: A skip-transfer descriptor issues no read request and so reads no card data.
// RULE2: A skip-transfer descriptor without marker or status request is dropped as a no-op.
// RULE3: With skip-transfer set the addresses are ignored and the user drives length zero.
// RULE4: A status request writes a status descriptor and raises a host interrupt after the last byte.
// RULE5: The host interrupt is raised only when ring interrupts are enabled and armed.
// RULE6: The user should request status about once per 32 or 64 descriptors and on the last one.
// RULE7: The user may pair skip-transfer with a status request to flush status when out of work.
// RULE8: A marker request returns a completion status to the user after the transfer ends.
// RULE9: A descriptor flagged with a queue error is not processed and the queue context records it.
// RULE10: The user echoes the 16-bit ring consumer index unchanged from the bypass output.
// RULE11: The user gives an 11-bit queue, an 8-bit function and a 3-bit port number.
// RULE12: The user pulses valid once per descriptor and the block drives ready when it can take one.
// RULE13: The user gives a 64-bit read address and a 64-bit write address per descriptor.
// RULE14: A descriptor moves only when valid and ready are both high, with fields stable then.
`timescale 1ns/1ps
`include "c2h_byp_consts.vh"

module c2h_mm_byp_in #(
	parameter AW = 8
) (
	input wire SYS_CLK,
	input wire ARST_N,
	// APB slave
	input wire [AW-1:0] PADDR,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	// Descriptor bypass input from user logic
	input wire DESCRIPTOR_VALID,
	output wire DESCRIPTOR_READY,
	input wire SKIP_TRANSFER_FLAG,
	input wire STATUS_IRQ_REQUEST,
	input wire MARKER_REQUEST,
	input wire QUEUE_ERROR_FLAG,
	input wire [`LEN_W-1:0] TRANSFER_LENGTH,
	input wire [`QID_W-1:0] QUEUE_NUMBER,
	input wire [`FUNC_W-1:0] FUNCTION_NUMBER,
	input wire [`CIDX_W-1:0] RING_CONSUMER_INDEX,
	input wire [`PORT_W-1:0] PORT_NUMBER,
	input wire [`ADDR_W-1:0] SOURCE_READ_ADDRESS,
	input wire [`ADDR_W-1:0] DEST_WRITE_ADDRESS,
	// Read request toward the PCIe request generator
	output wire RD_REQ_VALID,
	input wire RD_REQ_READY,
	output wire [`ADDR_W-1:0] RD_REQ_ADDR,
	output wire [`ADDR_W-1:0] RD_REQ_DEST_ADDR,
	output wire [`LEN_W-1:0] RD_REQ_LEN,
	output wire [`QID_W-1:0] RD_REQ_QUEUE,
	output wire [`FUNC_W-1:0] RD_REQ_FUNC,
	output wire [`PORT_W-1:0] RD_REQ_PORT,
	input wire RD_LAST_BYTE,
	// Status descriptor write toward the host
	output wire STS_WR_VALID,
	input wire STS_WR_READY,
	output wire [`QID_W-1:0] STS_WR_QUEUE,
	output wire [`FUNC_W-1:0] STS_WR_FUNC,
	output wire [`CIDX_W-1:0] STS_WR_CIDX,
	// Host interrupt request
	output wire HOST_IRQ_VALID,
	output wire [`QID_W-1:0] HOST_IRQ_QUEUE,
	output wire [`FUNC_W-1:0] HOST_IRQ_FUNC,
	// Marker completion toward user logic
	output wire MARKER_CPL_VALID,
	input wire MARKER_CPL_READY,
	output wire [`QID_W-1:0] MARKER_CPL_QUEUE,
	output wire [`CIDX_W-1:0] MARKER_CPL_CIDX,
	output wire [`PORT_W-1:0] MARKER_CPL_PORT,
	// Queue context error update
	output wire CTX_ERR_VALID,
	output wire [`QID_W-1:0] CTX_ERR_QUEUE,
	// Level interrupt from the event register
	output wire IRQ
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	reg rst_meta_r;
	reg rst_n_r;

	// Two flops release the asynchronous reset
	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_RDREQ = 6'h02;
	localparam [5:0] S_RDWAIT = 6'h04;
	localparam [5:0] S_STS = 6'h08;
	localparam [5:0] S_IRQ = 6'h10;
	localparam [5:0] S_MRK = 6'h20;

	reg [5:0] state_r;
	reg [5:0] state_nxt;

	// Registers and captured descriptor
	reg [1:0] ctrl_r;
	reg armed_r;
	reg [`EV_COUNT-1:0] int_en_r;
	reg [`QID_W-1:0] err_queue_r;
	reg [31:0] desc_count_r;
	reg [31:0] prdata_r;
	reg pslverr_r;
	reg sdi_r;
	reg mrk_r;
	reg [`LEN_W-1:0] len_r;
	reg [`QID_W-1:0] qid_r;
	reg [`FUNC_W-1:0] func_r;
	reg [`CIDX_W-1:0] cidx_r;
	reg [`PORT_W-1:0] port_r;
	reg [`ADDR_W-1:0] raddr_r;
	reg [`ADDR_W-1:0] waddr_r;
	reg ctx_err_r;
	reg [`QID_W-1:0] ctx_err_q_r;

	wire accept;
	wire is_error;
	wire is_nop;
	wire needs_read;
	wire irq_allowed;
	wire apb_setup;
	wire apb_access;
	wire wr_en;
	wire [`EV_COUNT-1:0] ev_set;
	wire [`EV_COUNT-1:0] ev_clr;
	wire [`EV_COUNT-1:0] ev_sticky;
	reg [31:0] rd_mux;
	reg rd_hit;

	// ------------------------------------------------------------
	// Descriptor handshake
	// ------------------------------------------------------------
	// RULE12: ready only when idle and enabled
	assign DESCRIPTOR_READY = state_r[0] & ctrl_r[`CTRL_ENABLE_BIT];
	// RULE14: transfer only on valid and ready
	assign accept = DESCRIPTOR_VALID & DESCRIPTOR_READY;

	desc_classify u_classify (
		.skip_transfer_flag(SKIP_TRANSFER_FLAG),
		.status_irq_request(STATUS_IRQ_REQUEST),
		.marker_request(MARKER_REQUEST),
		.queue_error_flag(QUEUE_ERROR_FLAG),
		.is_error(is_error),
		.is_nop(is_nop),
		.needs_read(needs_read)
	);

	// RULE5: interrupt needs ring enable and arm
	assign irq_allowed = ctrl_r[`CTRL_RING_IRQ_EN_BIT] & armed_r;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: begin
				if (accept) begin
					if (is_error || is_nop) begin
						state_nxt = S_IDLE;
					end else if (needs_read) begin
						state_nxt = S_RDREQ;
					end else if (STATUS_IRQ_REQUEST) begin
						// RULE1: skip goes straight to status
						state_nxt = S_STS;
					end else begin
						state_nxt = S_MRK;
					end
				end
			end
			S_RDREQ: begin
				if (RD_REQ_READY) begin
					state_nxt = S_RDWAIT;
				end
			end
			S_RDWAIT: begin
				// RULE4: act once the last byte is fetched
				if (RD_LAST_BYTE) begin
					if (sdi_r) begin
						state_nxt = S_STS;
					end else if (mrk_r) begin
						state_nxt = S_MRK;
					end else begin
						state_nxt = S_IDLE;
					end
				end
			end
			S_STS: begin
				if (STS_WR_READY) begin
					state_nxt = S_IRQ;
				end
			end
			S_IRQ: begin
				state_nxt = mrk_r ? S_MRK : S_IDLE;
			end
			S_MRK: begin
				if (MARKER_CPL_READY) begin
					state_nxt = S_IDLE;
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	// State register
	always @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= S_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------
	// Descriptor capture
	// ------------------------------------------------------------
	// Fields are taken once, on the accepting edge
	always @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			sdi_r <= 1'b0;
			mrk_r <= 1'b0;
			len_r <= {`LEN_W{1'b0}};
			qid_r <= {`QID_W{1'b0}};
			func_r <= {`FUNC_W{1'b0}};
			cidx_r <= {`CIDX_W{1'b0}};
			port_r <= {`PORT_W{1'b0}};
			raddr_r <= {`ADDR_W{1'b0}};
			waddr_r <= {`ADDR_W{1'b0}};
		end else if (accept) begin
			sdi_r <= STATUS_IRQ_REQUEST;
			mrk_r <= MARKER_REQUEST;
			qid_r <= QUEUE_NUMBER;
			func_r <= FUNCTION_NUMBER;
			cidx_r <= RING_CONSUMER_INDEX;
			port_r <= PORT_NUMBER;
			// RULE3: skip ignores address and length
			len_r <= SKIP_TRANSFER_FLAG ? {`LEN_W{1'b0}} : TRANSFER_LENGTH;
			raddr_r <= SKIP_TRANSFER_FLAG ? {`ADDR_W{1'b0}} : SOURCE_READ_ADDRESS;
			waddr_r <= SKIP_TRANSFER_FLAG ? {`ADDR_W{1'b0}} : DEST_WRITE_ADDRESS;
		end
	end

	// ------------------------------------------------------------
	// Queue error context update
	// ------------------------------------------------------------
	// RULE9: error descriptor updates the context only
	always @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctx_err_r <= 1'b0;
			ctx_err_q_r <= {`QID_W{1'b0}};
			err_queue_r <= {`QID_W{1'b0}};
		end else begin
			ctx_err_r <= accept & is_error;
			if (accept && is_error) begin
				ctx_err_q_r <= QUEUE_NUMBER;
				err_queue_r <= QUEUE_NUMBER;
			end
		end
	end

	// ------------------------------------------------------------
	// Outbound request outputs
	// ------------------------------------------------------------
	// RULE1: read request only for a real transfer
	assign RD_REQ_VALID = state_r[1];
	assign RD_REQ_ADDR = raddr_r;
	assign RD_REQ_DEST_ADDR = waddr_r;
	assign RD_REQ_LEN = len_r;
	assign RD_REQ_QUEUE = qid_r;
	assign RD_REQ_FUNC = func_r;
	assign RD_REQ_PORT = port_r;

	// RULE4: status descriptor write
	assign STS_WR_VALID = state_r[3];
	assign STS_WR_QUEUE = qid_r;
	assign STS_WR_FUNC = func_r;
	assign STS_WR_CIDX = cidx_r;

	// RULE5: interrupt pulse only when allowed
	assign HOST_IRQ_VALID = state_r[4] & irq_allowed;
	assign HOST_IRQ_QUEUE = qid_r;
	assign HOST_IRQ_FUNC = func_r;

	// RULE8: marker completion after the transfer
	assign MARKER_CPL_VALID = state_r[5];
	assign MARKER_CPL_QUEUE = qid_r;
	assign MARKER_CPL_CIDX = cidx_r;
	assign MARKER_CPL_PORT = port_r;

	assign CTX_ERR_VALID = ctx_err_r;
	assign CTX_ERR_QUEUE = ctx_err_q_r;

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	assign apb_setup = PSEL & ~PENABLE;
	assign apb_access = PSEL & PENABLE;
	assign wr_en = apb_access & PWRITE;
	assign PREADY = 1'b1;
	assign PRDATA = prdata_r;
	assign PSLVERR = apb_access & pslverr_r;

	// Read decode
	always @* begin
		rd_mux = 32'h00000000;
		rd_hit = 1'b1;
		case (PADDR)
			`REG_CTRL: rd_mux = {30'h00000000, ctrl_r};
			`REG_ARM: rd_mux = {31'h00000000, armed_r};
			`REG_INT_STATUS: rd_mux = {26'h0000000, ev_sticky};
			`REG_INT_CLEAR: rd_mux = 32'h00000000;
			`REG_INT_ENABLE: rd_mux = {26'h0000000, int_en_r};
			`REG_ERR_QUEUE: rd_mux = {21'h000000, err_queue_r};
			`REG_DESC_COUNT: rd_mux = desc_count_r;
			default: rd_hit = 1'b0;
		endcase
	end

	// Read data and error are set up in the setup cycle
	always @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (apb_setup) begin
			prdata_r <= PWRITE ? 32'h00000000 : rd_mux;
			pslverr_r <= ~rd_hit;
		end
	end

	// Writable registers; the arm bit drops when an interrupt fires
	always @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl_r <= `CTRL_RESET;
			int_en_r <= `INT_ENABLE_RESET;
			armed_r <= 1'b0;
		end else begin
			if (wr_en && PADDR == `REG_CTRL) begin
				ctrl_r <= PWDATA[1:0];
			end
			if (wr_en && PADDR == `REG_INT_ENABLE) begin
				int_en_r <= PWDATA[`EV_COUNT-1:0];
			end
			// RULE5: driver arms, interrupt disarms
			if (wr_en && PADDR == `REG_ARM && PWDATA[`ARM_BIT]) begin
				armed_r <= 1'b1;
			end else if (HOST_IRQ_VALID) begin
				armed_r <= 1'b0;
			end
		end
	end

	// Count of descriptors taken
	always @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			desc_count_r <= 32'h00000000;
		end else if (accept) begin
			desc_count_r <= desc_count_r + 32'h00000001;
		end
	end

	// ------------------------------------------------------------
	// Events and interrupt
	// ------------------------------------------------------------
	assign ev_set[`EV_DESC_DONE] = (state_r[0] == 1'b0) & (state_nxt == S_IDLE);
	// RULE2: no-op only counted
	assign ev_set[`EV_NOP] = accept & is_nop;
	assign ev_set[`EV_QUEUE_ERR] = accept & is_error;
	assign ev_set[`EV_MARKER] = state_r[5] & MARKER_CPL_READY;
	assign ev_set[`EV_HOST_IRQ] = HOST_IRQ_VALID;
	assign ev_set[`EV_IRQ_SUPPRESSED] = state_r[4] & ~irq_allowed;
	assign ev_clr = (wr_en && PADDR == `REG_INT_CLEAR) ? PWDATA[`EV_COUNT-1:0] : {`EV_COUNT{1'b0}};

	event_status #(
		.N(`EV_COUNT)
	) u_events (
		.clk(SYS_CLK),
		.rst_n(rst_n_r),
		.event_set(ev_set),
		.event_clr(ev_clr),
		.event_en(int_en_r),
		.event_sticky(ev_sticky),
		.irq(IRQ)
	);

endmodule // c2h_mm_byp_in

//--- src/desc_classify.v
`timescale 1ns/1ps
// ------------------------------------------------------------
// Descriptor classifier: picks the first step for a new descriptor
// ------------------------------------------------------------
module desc_classify (
	input wire skip_transfer_flag,
	input wire status_irq_request,
	input wire marker_request,
	input wire queue_error_flag,
	output reg is_error,
	output reg is_nop,
	output reg needs_read
);

	// Error wins over everything, then no-op, then real read
	always @* begin
		is_error = queue_error_flag;
		is_nop = 1'b0;
		needs_read = 1'b0;
		if (!queue_error_flag) begin
			// RULE2: skip with no side effect
			is_nop = skip_transfer_flag & ~status_irq_request & ~marker_request;
			// RULE1: skip issues no read
			needs_read = ~skip_transfer_flag;
		end
	end

endmodule // desc_classify

//--- src/event_status.v
`timescale 1ns/1ps
// ------------------------------------------------------------
// Sticky event bits, enable mask and level interrupt
// ------------------------------------------------------------
module event_status #(
	parameter N = 6
) (
	input wire clk,
	input wire rst_n,
	input wire [N-1:0] event_set,
	input wire [N-1:0] event_clr,
	input wire [N-1:0] event_en,
	output wire [N-1:0] event_sticky,
	output wire irq
);

	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_bit
			reg sticky_r;
			// Set wins over a clear in the same cycle
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					sticky_r <= 1'b0;
				end else if (event_set[i]) begin
					sticky_r <= 1'b1;
				end else if (event_clr[i]) begin
					sticky_r <= 1'b0;
				end
			end
			assign event_sticky[i] = sticky_r;
		end
	endgenerate

	// High while any enabled bit is set
	assign irq = |(event_sticky & event_en);

endmodule // event_status

//--- verif/c2h_mm_byp_in_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the bypass input block
// ----------------------------------------
module c2h_mm_byp_in_chk (
	input logic SYS_CLK,
	input logic ARST_N,
	input logic DESCRIPTOR_VALID,
	input logic DESCRIPTOR_READY,
	input logic SKIP_TRANSFER_FLAG,
	input logic STATUS_IRQ_REQUEST,
	input logic MARKER_REQUEST,
	input logic QUEUE_ERROR_FLAG,
	input logic [10:0] QUEUE_NUMBER,
	input logic [15:0] RING_CONSUMER_INDEX,
	input logic [63:0] SOURCE_READ_ADDRESS,
	input logic RD_REQ_VALID,
	input logic RD_REQ_READY,
	input logic [63:0] RD_REQ_ADDR,
	input logic RD_LAST_BYTE,
	input logic STS_WR_VALID,
	input logic STS_WR_READY,
	input logic [15:0] STS_WR_CIDX,
	input logic HOST_IRQ_VALID,
	input logic MARKER_CPL_VALID,
	input logic CTX_ERR_VALID,
	input logic [10:0] CTX_ERR_QUEUE
);
	logic sdi_r;
	logic mk_r;
	logic [1:0] sts_r;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	// Flags of the descriptor in flight, status handshake history
	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sdi_r <= 1'b0;
			mk_r <= 1'b0;
			sts_r <= 2'h0;
		end else begin
			if (DESCRIPTOR_VALID && DESCRIPTOR_READY) begin
				sdi_r <= STATUS_IRQ_REQUEST;
				mk_r <= MARKER_REQUEST;
			end
			sts_r <= {sts_r[0], STS_WR_VALID && STS_WR_READY};
		end
	end
	sequence acc_s;
		DESCRIPTOR_VALID && DESCRIPTOR_READY;
	endsequence
	sequence pulse_s;
		HOST_IRQ_VALID ##1 !HOST_IRQ_VALID;
	endsequence
	skip_no_read_a: assert property (acc_s ##0 SKIP_TRANSFER_FLAG |=> !RD_REQ_VALID)
		else $error("read request for a skip descriptor");
	nop_quiet_a: assert property (acc_s ##0 (SKIP_TRANSFER_FLAG && !STATUS_IRQ_REQUEST &&
		!MARKER_REQUEST && !QUEUE_ERROR_FLAG) |=> DESCRIPTOR_READY && !(RD_REQ_VALID ||
		STS_WR_VALID || MARKER_CPL_VALID || CTX_ERR_VALID || HOST_IRQ_VALID))
		else $error("activity after a no-op descriptor");
	err_ctx_a: assert property (acc_s ##0 QUEUE_ERROR_FLAG |=> CTX_ERR_VALID &&
		!RD_REQ_VALID && CTX_ERR_QUEUE == $past(QUEUE_NUMBER))
		else $error("queue error not reported");
	read_issue_a: assert property (acc_s ##0 (!SKIP_TRANSFER_FLAG && !QUEUE_ERROR_FLAG) |=>
		RD_REQ_VALID && RD_REQ_ADDR == $past(SOURCE_READ_ADDRESS))
		else $error("read request missing or wrong address");
	rd_hold_a: assert property (RD_REQ_VALID && !RD_REQ_READY |=> RD_REQ_VALID &&
		$stable(RD_REQ_ADDR))
		else $error("read request dropped before ready");
	sts_last_a: assert property (RD_LAST_BYTE && sdi_r |-> ##[1:2] STS_WR_VALID)
		else $error("no status write after last byte");
	sts_skip_a: assert property (acc_s ##0 (SKIP_TRANSFER_FLAG && STATUS_IRQ_REQUEST &&
		!QUEUE_ERROR_FLAG) |=> STS_WR_VALID && STS_WR_CIDX == $past(RING_CONSUMER_INDEX))
		else $error("no status write for skip descriptor");
	irq_pulse_a: assert property (HOST_IRQ_VALID |-> (sts_r != 2'h0) ##0 pulse_s)
		else $error("host interrupt without status write");
	mrk_only_a: assert property (MARKER_CPL_VALID |-> mk_r)
		else $error("marker completion not requested");
	ready_drop_a: assert property (acc_s ##0 (!QUEUE_ERROR_FLAG && (!SKIP_TRANSFER_FLAG ||
		STATUS_IRQ_REQUEST || MARKER_REQUEST)) |=> !DESCRIPTOR_READY)
		else $error("ready stayed high while busy");
endmodule // c2h_mm_byp_in_chk

bind c2h_mm_byp_in c2h_mm_byp_in_chk u_chk (.*);

//--- verif/c2h_mm_byp_in_test.sv
`timescale 1ns/1ps
`include "c2h_byp_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("ERROR %0t got %0h exp %0h", $time, a, b); end end
module c2h_mm_byp_in_test;
	logic SYS_CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err, slow, armed;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic DESCRIPTOR_VALID, DESCRIPTOR_READY, SKIP_TRANSFER_FLAG, STATUS_IRQ_REQUEST;
	logic MARKER_REQUEST, QUEUE_ERROR_FLAG, RD_REQ_VALID, RD_REQ_READY, RD_LAST_BYTE, IRQ;
	logic STS_WR_VALID, STS_WR_READY, HOST_IRQ_VALID, MARKER_CPL_VALID, MARKER_CPL_READY;
	logic CTX_ERR_VALID;
	logic [27:0] TRANSFER_LENGTH, RD_REQ_LEN;
	logic [10:0] QUEUE_NUMBER, RD_REQ_QUEUE, STS_WR_QUEUE, HOST_IRQ_QUEUE, eq;
	logic [10:0] MARKER_CPL_QUEUE, CTX_ERR_QUEUE;
	logic [7:0] FUNCTION_NUMBER, RD_REQ_FUNC, STS_WR_FUNC, HOST_IRQ_FUNC;
	logic [15:0] RING_CONSUMER_INDEX, STS_WR_CIDX, MARKER_CPL_CIDX;
	logic [2:0] PORT_NUMBER, RD_REQ_PORT, MARKER_CPL_PORT;
	logic [63:0] SOURCE_READ_ADDRESS, DEST_WRITE_ADDRESS, RD_REQ_ADDR, RD_REQ_DEST_ADDR;
	logic [63:0] seed = 64'd76;
	logic [67:0] exp_q[$];
	int error_cnt = 0;
	int total_checks = 0;

	c2h_mm_byp_in u_dut (.*);
	req_sink_model u_sink (.clk(SYS_CLK), .rst_n(ARST_N), .slow(slow), .rd_valid(RD_REQ_VALID),
		.rd_ready(RD_REQ_READY), .rd_last(RD_LAST_BYTE), .sts_ready(STS_WR_READY),
		.mk_ready(MARKER_CPL_READY));

	// ----------------------------------------
	// Clock, watchdog, helpers
	// ----------------------------------------
	initial begin
		SYS_CLK = 1'b0;
		forever #10 SYS_CLK = ~SYS_CLK;
	end
	initial begin
		#400000;
		error_cnt++;
		test_done();
	end
	function automatic logic [63:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 7;
		seed ^= seed << 17;
		return seed;
	endfunction
	task test_done();
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One APB transfer, waits for PREADY
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		do @(posedge SYS_CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task put(input logic v, input logic [3:0] f, input logic [63:0] a, w, r, input logic [27:0] n);
		DESCRIPTOR_VALID <= v;
		{SKIP_TRANSFER_FLAG, STATUS_IRQ_REQUEST, MARKER_REQUEST, QUEUE_ERROR_FLAG} <= f;
		SOURCE_READ_ADDRESS <= a;
		DEST_WRITE_ADDRESS <= w;
		TRANSFER_LENGTH <= n;
		QUEUE_NUMBER <= r[10:0];
		FUNCTION_NUMBER <= r[23:16];
		PORT_NUMBER <= r[26:24];
		RING_CONSUMER_INDEX <= r[63:48];
	endtask
	// One descriptor, expected results noted in order
	task desc(input logic sk, sd, mk, er);
		logic [63:0] a, w, r;
		logic [27:0] n;
		a = xs();
		w = xs();
		r = xs();
		n = sk ? 28'h0 : {20'h0, r[39:32]};
		do @(posedge SYS_CLK); while (DESCRIPTOR_READY !== 1'b1);
		put(1'b1, {sk, sd, mk, er}, a, w, r, n);
		@(posedge SYS_CLK);
		put(1'b0, ~{sk, sd, mk, er}, ~a, ~w, ~r, ~n);
		// Ready stays up only for error and no-op descriptors
		@(negedge SYS_CLK);
		`CHK(DESCRIPTOR_READY, er || (sk && !sd && !mk))
		if (er) begin
			exp_q.push_back({4'h5, 53'h0, r[10:0]});
			eq = r[10:0];
		end else begin
			if (!sk) exp_q.push_back({4'h1, a ^ w ^ {14'h0, n, r[10:0], r[23:16], r[26:24]}});
			if (sd) exp_q.push_back({4'h2, 29'h0, r[10:0], r[23:16], r[63:48]});
			if (sd && armed) begin
				exp_q.push_back({4'h3, 45'h0, r[10:0], r[23:16]});
				armed = 1'b0;
			end
			if (mk) exp_q.push_back({4'h4, 34'h0, r[10:0], r[63:48], r[26:24]});
		end
		repeat (2) @(posedge SYS_CLK);
		do @(posedge SYS_CLK); while (DESCRIPTOR_READY !== 1'b1);
	endtask
	task take(input logic [67:0] o);
		logic [67:0] e;
		e = 68'h0;
		if (exp_q.size() == 0) `CHK(o, e)
		else begin
			e = exp_q.pop_front();
			`CHK(o, e)
		end
	endtask

	// ----------------------------------------
	// Output watcher
	// ----------------------------------------
	always @(posedge SYS_CLK) begin
		if (RD_REQ_VALID && RD_REQ_READY)
			take({4'h1, RD_REQ_ADDR ^ RD_REQ_DEST_ADDR ^ {14'h0, RD_REQ_LEN, RD_REQ_QUEUE,
				RD_REQ_FUNC, RD_REQ_PORT}});
		if (STS_WR_VALID && STS_WR_READY)
			take({4'h2, 29'h0, STS_WR_QUEUE, STS_WR_FUNC, STS_WR_CIDX});
		if (HOST_IRQ_VALID)
			take({4'h3, 45'h0, HOST_IRQ_QUEUE, HOST_IRQ_FUNC});
		if (MARKER_CPL_VALID && MARKER_CPL_READY)
			take({4'h4, 34'h0, MARKER_CPL_QUEUE, MARKER_CPL_CIDX, MARKER_CPL_PORT});
		if (CTX_ERR_VALID)
			take({4'h5, 53'h0, CTX_ERR_QUEUE});
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		ARST_N = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		slow = 1'b0;
		armed = 1'b0;
		put(1'b0, 4'h0, 64'h0, 64'h0, 64'h0, 28'h0);
		repeat (16) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
		repeat (4) @(posedge SYS_CLK);
		`CHK(DESCRIPTOR_READY, 1'b0)
		apb(1'b0, `REG_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, 8'h1c, 32'h0);
		`CHK({err, rd}, 33'h100000000)
		apb(1'b1, `REG_CTRL, 32'h3);
		apb(1'b1, `REG_INT_ENABLE, 32'h3f);
		for (int i = 0; i < 16; i++) begin
			slow <= i[0] ^ i[1];
			if (i < 6) begin
				apb(1'b1, `REG_ARM, 32'h1);
				armed = 1'b1;
			end
			// status requests spread over the batch
			desc(i[0], i[1], i[2], i[3]);
		end
		`CHK(exp_q.size(), 0)
		apb(1'b0, `REG_INT_STATUS, 32'h0);
		`CHK(rd[5:0], 6'h3f)
		`CHK(IRQ, 1'b1)
		apb(1'b0, `REG_DESC_COUNT, 32'h0);
		`CHK(rd, 32'd16)
		apb(1'b0, `REG_ERR_QUEUE, 32'h0);
		`CHK(rd[10:0], eq)
		apb(1'b1, `REG_INT_CLEAR, 32'h3f);
		apb(1'b0, `REG_INT_CLEAR, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, `REG_INT_STATUS, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b1, `REG_INT_ENABLE, 32'h0);
		desc(1'b1, 1'b0, 1'b0, 1'b0);
		repeat (2) @(posedge SYS_CLK);
		`CHK(IRQ, 1'b0)
		apb(1'b0, `REG_INT_STATUS, 32'h0);
		`CHK(rd, 32'h2)
		apb(1'b1, `REG_INT_ENABLE, 32'h2);
		repeat (2) @(posedge SYS_CLK);
		`CHK(IRQ, 1'b1)
		// ring interrupts off: status only, arm kept
		apb(1'b1, `REG_CTRL, 32'h1);
		apb(1'b1, `REG_ARM, 32'h1);
		armed = 1'b0;
		// final skip descriptor asks for status
		desc(1'b1, 1'b1, 1'b0, 1'b0);
		apb(1'b0, `REG_ARM, 32'h0);
		`CHK(rd, 32'h1)
		apb(1'b0, `REG_INT_STATUS, 32'h0);
		`CHK(rd, 32'h23)
		`CHK(exp_q.size(), 0)
		test_done();
	end
endmodule // c2h_mm_byp_in_test

//--- verif/req_sink_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far side: read engine, status writer, marker sink
// ----------------------------------------
module req_sink_model (
	input logic clk,
	input logic rst_n,
	input logic slow,
	input logic rd_valid,
	output logic rd_ready,
	output logic rd_last,
	output logic sts_ready,
	output logic mk_ready
);
	logic [7:0] lfsr_r;
	logic [3:0] cnt_r;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr_r <= 8'h5a;
			cnt_r <= 4'h0;
			rd_last <= 1'b0;
		end else begin
			lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
			rd_last <= (cnt_r == 4'h1);
			if (rd_valid && rd_ready)
				cnt_r <= slow ? 4'h9 : 4'h2;
			else if (cnt_r != 4'h0)
				cnt_r <= cnt_r - 4'h1;
		end
	end
	// Ready levels stall randomly in slow mode
	assign rd_ready = !slow || lfsr_r[0];
	assign sts_ready = !slow || lfsr_r[2];
	assign mk_ready = !slow || lfsr_r[5];
endmodule // req_sink_model
